// *** core/pms_consts.svh ***
// Constants for the pump mode sequencer: offsets, fields, resets, timings
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

`define PMS_CTRL_OFS 8'h00
`define PMS_VOLUME_OFS 8'h04
`define PMS_DRATE_OFS 8'h08
`define PMS_FRATE_OFS 8'h0C
`define PMS_STATUS_OFS 8'h10
`define PMS_REMAIN_OFS 8'h14

`define PMS_CTRL_AUTOLOAD_LSB 0
`define PMS_ST_MODE_LSB 0
`define PMS_ST_OP_LSB 4
`define PMS_ST_REF_BIT 8
`define PMS_ST_ROT_BIT 9
`define PMS_ST_LIN_BIT 10
`define PMS_ST_READY_BIT 11
`define PMS_ST_REFILL_BIT 12

`define PMS_AUTOLOAD_MANUAL 2'h0
`define PMS_AUTOLOAD_EMPTY 2'h1
`define PMS_AUTOLOAD_EVERY 2'h2

`define PMS_VOLUME_RST 16'h0004
`define PMS_DRATE_RST 16'h03E8
`define PMS_FRATE_RST 16'h03E8

`define PMS_CLK_KHZ 25000
`define PMS_PRIME_TIME_MS 120000
`define PMS_BUBBLE_TIME_MS 2000
`define PMS_REF_TIME_MS 500
`define PMS_DEBOUNCE_US 1000

`endif

// *** core/pms_pkg.sv ***
// Types shared by the pump mode sequencer
package pms_pkg;

  typedef enum logic [3:0] {
    PMS_SETUP, PMS_PRIME, PMS_PRIME_2, PMS_PRIME_3, PMS_BUBBLE,
    PMS_BUBBLE_2, PMS_BUBBLE_3, PMS_DISPENSE, PMS_METER
  } pms_mode_t;

  typedef enum logic [2:0] {
    PMS_OP_IDLE, PMS_OP_REF, PMS_OP_PRIME, PMS_OP_BUBBLE,
    PMS_OP_DISPENSE, PMS_OP_METER, PMS_OP_LOAD
  } pms_op_t;

  typedef struct packed {
    logic arrow;
    logic start;
    logic stop;
    logic reference;
    logic fault_reset;
  } pms_panel_t;

  typedef struct packed {
    logic rotary;
    logic linear;
  } pms_fault_t;

endpackage

// *** core/pms_debounce.sv ***
// Input synchroniser, debounce filter and rising-edge detector
`timescale 1ns/1ps
module pms_debounce #(
  parameter int STABLE = 25000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic level,
  output logic rise
);
  logic sync1;
  logic sync2;
  logic [31:0] cnt;

  wire changed = sync2 != level;
  wire settle = changed && (cnt >= 32'(STABLE - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= din;
      sync2 <= sync1;
    end
  end

  // Level must hold for STABLE cycles before it is believed
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 32'h0;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      cnt <= (changed && !settle) ? cnt + 32'h1 : 32'h0;
      if (settle) begin
        level <= sync2;
      end
      rise <= settle && sync2;
    end
  end
endmodule

// *** core/pms_sequencer.sv ***
// Pump mode sequencer: mode stepping, operations, PLC handshake, APB registers
`timescale 1ns/1ps
`include "pms_consts.svh"
module pms_sequencer #(
  parameter logic [31:0] PRIME_CYCLES = 32'(64'(`PMS_PRIME_TIME_MS) * `PMS_CLK_KHZ),
  parameter logic [31:0] BUBBLE_CYCLES = 32'(`PMS_BUBBLE_TIME_MS * `PMS_CLK_KHZ),
  parameter logic [31:0] REF_CYCLES = 32'(`PMS_REF_TIME_MS * `PMS_CLK_KHZ),
  parameter int DEBOUNCE_CYCLES = `PMS_DEBOUNCE_US * `PMS_CLK_KHZ / 1000,
  parameter logic [15:0] CHAMBER_UNITS = 16'h03E8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pms_pkg::pms_panel_t panel,
  input wire pms_pkg::pms_fault_t fault_in,
  input wire logic trigger_in,
  input wire logic refill_req_in,
  output logic ready_out,
  output logic refill_needed_out,
  output logic pump_step,
  output logic pump_active,
  output pms_pkg::pms_fault_t fault_out
);

  function automatic logic known_addr(input logic [7:0] a);
    return a == `PMS_CTRL_OFS || a == `PMS_VOLUME_OFS || a == `PMS_DRATE_OFS ||
           a == `PMS_FRATE_OFS || a == `PMS_STATUS_OFS || a == `PMS_REMAIN_OFS;
  endfunction

  function automatic pms_pkg::pms_mode_t next_mode(input pms_pkg::pms_mode_t m);
    unique case (m)
      pms_pkg::PMS_SETUP: return pms_pkg::PMS_PRIME;
      pms_pkg::PMS_PRIME: return pms_pkg::PMS_PRIME_2;
      pms_pkg::PMS_PRIME_2: return pms_pkg::PMS_PRIME_3;
      pms_pkg::PMS_PRIME_3: return pms_pkg::PMS_BUBBLE;
      pms_pkg::PMS_BUBBLE: return pms_pkg::PMS_BUBBLE_2;
      pms_pkg::PMS_BUBBLE_2: return pms_pkg::PMS_BUBBLE_3;
      pms_pkg::PMS_BUBBLE_3: return pms_pkg::PMS_DISPENSE;
      pms_pkg::PMS_DISPENSE: return pms_pkg::PMS_METER;
      pms_pkg::PMS_METER: return pms_pkg::PMS_SETUP;
      default: return pms_pkg::PMS_SETUP;
    endcase
  endfunction

  pms_pkg::pms_mode_t mode;
  pms_pkg::pms_op_t op;
  pms_pkg::pms_op_t next_op;
  logic referenced;
  logic [1:0] autoload;
  logic [15:0] volume;
  logic [15:0] delivery_rate_setting;
  logic [15:0] fill_rate_setting;
  logic [15:0] vol_run;
  logic [15:0] remaining;
  logic [15:0] delivered;
  logic [15:0] div_cnt;
  logic [31:0] timer;
  logic meter_by_trig;
  logic auto_pend;
  logic trig_level;
  logic trig_rise;
  logic refill_rise;

  // Both inputs come from a relay or opto contact and may bounce
  pms_debounce #(.STABLE(DEBOUNCE_CYCLES)) u_trig_db (
    .clk(clk),
    .reset(reset),
    .din(trigger_in),
    .level(trig_level),
    .rise(trig_rise)
  );

  pms_debounce #(.STABLE(DEBOUNCE_CYCLES)) u_refill_db (
    .clk(clk),
    .reset(reset),
    .din(refill_req_in),
    .level(),
    .rise(refill_rise)
  );

  // Decoding
  wire fault_any = fault_out.rotary || fault_out.linear;
  wire idle = op == pms_pkg::PMS_OP_IDLE;
  wire can_move = idle && referenced && !fault_any;
  wire need_fill = remaining < volume;
  wire in_disp = mode == pms_pkg::PMS_DISPENSE;
  wire in_meter = mode == pms_pkg::PMS_METER;
  wire trig_go = trig_rise && (in_disp || in_meter);
  wire start_prime = can_move && mode == pms_pkg::PMS_PRIME && panel.start;
  wire start_bub = can_move && mode == pms_pkg::PMS_BUBBLE && panel.start;
  wire start_disp = can_move && in_disp && !need_fill && (panel.start || trig_go);
  wire start_meter = can_move && in_meter && !need_fill && (panel.start || trig_go);
  wire auto_go = auto_pend && (autoload == `PMS_AUTOLOAD_EVERY || need_fill);
  wire start_load = can_move && remaining != CHAMBER_UNITS && (refill_rise || auto_go);
  wire start_ref = idle && !fault_any && panel.reference;
  wire delivering = op == pms_pkg::PMS_OP_DISPENSE || op == pms_pkg::PMS_OP_METER;
  wire moving = !idle && op != pms_pkg::PMS_OP_REF;
  // Status follows the coming op so ready and busy never overlap
  wire next_moving = next_op != pms_pkg::PMS_OP_IDLE && next_op != pms_pkg::PMS_OP_REF;
  wire fault_new = fault_in.rotary || fault_in.linear;
  wire [15:0] rate_sel = delivering ? delivery_rate_setting : fill_rate_setting;
  wire [15:0] rate = (rate_sel == 16'h0) ? 16'h0001 : rate_sel;
  wire step_en = moving && div_cnt >= rate - 16'h0001;
  wire disp_done = delivered >= vol_run || remaining == 16'h0;
  wire meter_stop = meter_by_trig ? !trig_level : panel.stop;
  wire meter_done = meter_stop || remaining == 16'h0;
  wire run_end = (op == pms_pkg::PMS_OP_DISPENSE && disp_done) ||
                 (op == pms_pkg::PMS_OP_METER && meter_done);
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pready && pwrite && !pslverr;
  wire arrow_ok = idle && referenced && panel.arrow;

  always_comb begin
    next_op = op;
    unique case (op)
      pms_pkg::PMS_OP_IDLE: begin
        if (start_ref) begin
          next_op = pms_pkg::PMS_OP_REF;
        end else if (start_prime) begin
          next_op = pms_pkg::PMS_OP_PRIME;
        end else if (start_bub) begin
          next_op = pms_pkg::PMS_OP_BUBBLE;
        end else if (start_disp) begin
          next_op = pms_pkg::PMS_OP_DISPENSE;
        end else if (start_meter) begin
          next_op = pms_pkg::PMS_OP_METER;
        end else if (start_load) begin
          next_op = pms_pkg::PMS_OP_LOAD;
        end
      end
      pms_pkg::PMS_OP_REF: begin
        if (timer >= REF_CYCLES - 32'h1) begin
          next_op = pms_pkg::PMS_OP_IDLE;
        end
      end
      pms_pkg::PMS_OP_PRIME: begin
        if (panel.stop || timer >= PRIME_CYCLES - 32'h1) begin
          next_op = pms_pkg::PMS_OP_IDLE;
        end
      end
      pms_pkg::PMS_OP_BUBBLE: begin
        // Stop button deliberately not looked at here
        if (timer >= BUBBLE_CYCLES - 32'h1) begin
          next_op = pms_pkg::PMS_OP_IDLE;
        end
      end
      pms_pkg::PMS_OP_DISPENSE: begin
        if (disp_done) begin
          next_op = pms_pkg::PMS_OP_IDLE;
        end
      end
      pms_pkg::PMS_OP_METER: begin
        if (meter_done) begin
          next_op = pms_pkg::PMS_OP_IDLE;
        end
      end
      pms_pkg::PMS_OP_LOAD: begin
        if (remaining >= CHAMBER_UNITS) begin
          next_op = pms_pkg::PMS_OP_IDLE;
        end
      end
    endcase
    if (fault_any) begin
      next_op = pms_pkg::PMS_OP_IDLE;
    end
  end

  // Operation state and timers
  always_ff @(posedge clk) begin
    if (reset) begin
      op <= pms_pkg::PMS_OP_IDLE;
      timer <= 32'h0;
      div_cnt <= 16'h0;
    end else begin
      op <= next_op;
      timer <= (next_op != op) ? 32'h0 : timer + 32'h1;
      div_cnt <= (step_en || !moving || next_op != op) ? 16'h0 : div_cnt + 16'h1;
    end
  end

  // Mode stepping only while idle, so a run never changes mode under it
  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= pms_pkg::PMS_SETUP;
    end else if (arrow_ok) begin
      mode <= next_mode(mode);
    end
  end

  // Faults: a new fault wins over a reset press in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_out <= '0;
    end else begin
      fault_out.rotary <= fault_in.rotary || (fault_out.rotary && !panel.fault_reset);
      fault_out.linear <= fault_in.linear || (fault_out.linear && !panel.fault_reset);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || fault_any) begin
      referenced <= 1'b0;
    end else if (op == pms_pkg::PMS_OP_REF && next_op == pms_pkg::PMS_OP_IDLE) begin
      referenced <= 1'b1;
    end
  end

  // Chamber contents; piston position is unknown until reloaded
  always_ff @(posedge clk) begin
    if (reset) begin
      remaining <= 16'h0;
    end else if (op == pms_pkg::PMS_OP_REF) begin
      remaining <= 16'h0;
    end else if (step_en && delivering && remaining != 16'h0 && !run_end) begin
      remaining <= remaining - 16'h1;
    end else if (step_en && op == pms_pkg::PMS_OP_LOAD && remaining < CHAMBER_UNITS) begin
      remaining <= remaining + 16'h1;
    end
  end

  // Volume is taken at the start so software may load the next one early
  always_ff @(posedge clk) begin
    if (reset) begin
      vol_run <= 16'h0;
      delivered <= 16'h0;
      meter_by_trig <= 1'b0;
    end else if (idle) begin
      vol_run <= volume;
      delivered <= 16'h0;
      meter_by_trig <= trig_go && !panel.start;
    end else if (step_en && delivering && !run_end) begin
      delivered <= delivered + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || fault_any) begin
      auto_pend <= 1'b0;
    end else if (run_end) begin
      auto_pend <= autoload != `PMS_AUTOLOAD_MANUAL;
    end else if (idle) begin
      auto_pend <= 1'b0;
    end
  end

  // Handshake outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_out <= 1'b0;
      refill_needed_out <= 1'b0;
      pump_step <= 1'b0;
      pump_active <= 1'b0;
    end else begin
      ready_out <= next_op == pms_pkg::PMS_OP_IDLE && referenced && !fault_any &&
                   !fault_new;
      refill_needed_out <= need_fill;
      pump_step <= step_en && !run_end;
      pump_active <= next_moving;
    end
  end

  // APB register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      autoload <= `PMS_AUTOLOAD_MANUAL;
      volume <= `PMS_VOLUME_RST;
      delivery_rate_setting <= `PMS_DRATE_RST;
      fill_rate_setting <= `PMS_FRATE_RST;
    end else if (apb_wr) begin
      unique case (paddr)
        `PMS_CTRL_OFS: autoload <= pwdata[`PMS_CTRL_AUTOLOAD_LSB +: 2];
        `PMS_VOLUME_OFS: volume <= pwdata[15:0];
        `PMS_DRATE_OFS: delivery_rate_setting <= pwdata[15:0];
        `PMS_FRATE_OFS: fill_rate_setting <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // APB read data, answered one access cycle after setup
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0;
    unique case (paddr)
      `PMS_CTRL_OFS: next_prdata[`PMS_CTRL_AUTOLOAD_LSB +: 2] = autoload;
      `PMS_VOLUME_OFS: next_prdata[15:0] = volume;
      `PMS_DRATE_OFS: next_prdata[15:0] = delivery_rate_setting;
      `PMS_FRATE_OFS: next_prdata[15:0] = fill_rate_setting;
      `PMS_STATUS_OFS: begin
        next_prdata[`PMS_ST_MODE_LSB +: 4] = mode;
        next_prdata[`PMS_ST_OP_LSB +: 3] = op;
        next_prdata[`PMS_ST_REF_BIT] = referenced;
        next_prdata[`PMS_ST_ROT_BIT] = fault_out.rotary;
        next_prdata[`PMS_ST_LIN_BIT] = fault_out.linear;
        next_prdata[`PMS_ST_READY_BIT] = ready_out;
        next_prdata[`PMS_ST_REFILL_BIT] = refill_needed_out;
      end
      `PMS_REMAIN_OFS: next_prdata[15:0] = remaining;
      default: next_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !known_addr(paddr);
      if (apb_setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule

// *** bench/pms_sequencer_monitor.sv ***
// Port assertions for the pump mode sequencer
`timescale 1ns/1ps
module pms_sequencer_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire pms_pkg::pms_panel_t panel,
  input wire pms_pkg::pms_fault_t fault_in,
  input wire logic ready_out,
  input wire logic pump_step,
  input wire logic pump_active,
  input wire pms_pkg::pms_fault_t fault_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_fault;
    fault_in.rotary || fault_in.linear;
  endsequence
  property p_apb_answer;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("answer not one cycle");
  property p_err;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_fault_set;
    s_fault |-> ##[1:2] (fault_out != 2'h0);
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");
  property p_fault_hold;
    fault_out.rotary && !panel.fault_reset |=> fault_out.rotary;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
  property p_fault_clear;
    panel.fault_reset && !fault_in.rotary && !fault_in.linear |=> fault_out == 2'h0;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");
  property p_fault_ready;
    (fault_out != 2'h0) |-> !ready_out;
  endproperty
  a_fault_ready: assert property (p_fault_ready) else $error("ready with fault");
  property p_fault_abort;
    $rose(fault_out != 2'h0) |-> ##[0:1] !pump_active;
  endproperty
  a_fault_abort: assert property (p_fault_abort) else $error("motion kept");
  property p_busy;
    pump_active |-> !ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while moving");
  property p_step;
    pump_step |-> pump_active || $past(pump_active);
  endproperty
  a_step: assert property (p_step) else $error("step while stopped");
  property p_no_ref;
    $fell(reset) |-> !pump_active [*8];
  endproperty
  a_no_ref: assert property (p_no_ref) else $error("motion before reference");
endmodule

bind pms_sequencer pms_sequencer_monitor pms_sequencer_monitor_inst (.clk(clk),
  .reset(reset), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .panel(panel), .fault_in(fault_in), .ready_out(ready_out), .pump_step(pump_step),
  .pump_active(pump_active), .fault_out(fault_out));

// *** bench/pms_plc_model.sv ***
// Controller-side model: bouncing trigger and refill request lines
`timescale 1ns/1ps
module pms_plc_model (
  input wire logic clk,
  input wire logic trig_cmd,
  input wire logic load_cmd,
  output logic trigger_in,
  output logic refill_req_in
);
  logic [1:0] cmd_q = 2'h0;
  logic [1:0] bt = 2'h0;
  logic [1:0] bl = 2'h0;
  initial begin
    trigger_in = 1'b0;
    refill_req_in = 1'b0;
  end
  // Chatter after every change so the input filter is really exercised
  always @(posedge clk) begin
    cmd_q <= {trig_cmd, load_cmd};
    bt <= (trig_cmd != cmd_q[1]) ? 2'h3 : ((bt != 2'h0) ? bt - 2'h1 : 2'h0);
    bl <= (load_cmd != cmd_q[0]) ? 2'h3 : ((bl != 2'h0) ? bl - 2'h1 : 2'h0);
    trigger_in <= (bt != 2'h0) ? ~trigger_in : trig_cmd;
    refill_req_in <= (bl != 2'h0) ? ~refill_req_in : load_cmd;
  end
endmodule

// *** bench/pms_sequencer_tb.sv ***
// Self-checking bench for the pump mode sequencer
`timescale 1ns/1ps
module pms_sequencer_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig_cmd = 1'b0, load_cmd = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, ready_out, refill_needed_out, pump_step, pump_active;
  logic trigger_in, refill_req_in;
  pms_pkg::pms_panel_t panel = 5'h00;
  pms_pkg::pms_fault_t fault_in = 2'h0, fault_out;
  logic [32:0] expq[$];
  int n_mismatch = 0, samples_checked = 0, steps = 0;
  always #20 clk = ~clk;
  pms_sequencer #(.PRIME_CYCLES(32'hC8), .BUBBLE_CYCLES(32'h32), .REF_CYCLES(32'h14),
    .DEBOUNCE_CYCLES(4), .CHAMBER_UNITS(16'h0014)) pms_sequencer_inst (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .panel(panel),
    .fault_in(fault_in), .trigger_in(trigger_in), .refill_req_in(refill_req_in),
    .ready_out(ready_out), .refill_needed_out(refill_needed_out), .pump_step(pump_step),
    .pump_active(pump_active), .fault_out(fault_out));
  pms_plc_model pms_plc_model_inst (.clk(clk), .trig_cmd(trig_cmd), .load_cmd(load_cmd),
    .trigger_in(trigger_in), .refill_req_in(refill_req_in));
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task press(input logic [4:0] v);
    @(posedge clk);
    panel <= v;
    @(posedge clk);
    panel <= 5'h00;
    tick(2);
  endtask
  task wait_rdy(input int n);
    for (int i = 0; i < n && ready_out !== 1'b1; i++) @(posedge clk);
    chk(33'(ready_out), 33'h1);
  endtask
  always @(posedge clk) if (pump_step === 1'b1) steps <= steps + 1;
  // Read results are judged apart from the driver, oldest note first
  always @(posedge clk) if (psel && penable && pready === 1'b1 && !pwrite)
    chk({pslverr, prdata}, expq.pop_front());
  initial begin
    #800000;
    n_mismatch++;
    summarize;
  end
  initial begin
    void'($urandom(32'h350A));
    tick(10);
    reset <= 1'b0;
    tick(1);
    rd(8'h04, 33'h4);
    rd(8'h08, 33'h3E8);
    rd(8'h10, 33'h1000);
    rd(8'h20, 33'h100000000);
    apb(1'b1, 8'h0C, 32'h1);
    rv = $urandom;
    apb(1'b1, 8'h04, rv);
    rd(8'h04, {17'h0, rv[15:0]});
    apb(1'b1, 8'h04, 32'h3);
    press(5'h02);
    wait_rdy(40);
    rd(8'h10, 33'h1900);
    trig_cmd <= 1'b1;
    tick(20);
    chk(33'(pump_active), 33'h0);
    trig_cmd <= 1'b0;
    tick(20);
    press(5'h10);
    rd(8'h10, 33'h1901);
    press(5'h08);
    chk(33'(pump_active), 33'h1);
    press(5'h04);
    chk(33'(pump_active), 33'h0);
    press(5'h08);
    tick(190);
    chk(33'(pump_active), 33'h1);
    wait_rdy(30);
    for (int k = 2; k <= 4; k++) begin
      press(5'h10);
      rd(8'h10, 33'h1900 + 33'(k));
    end
    press(5'h08);
    press(5'h04);
    chk(33'(pump_active), 33'h1);
    wait_rdy(80);
    for (int k = 5; k <= 7; k++) begin
      press(5'h10);
      rd(8'h10, 33'h1900 + 33'(k));
    end
    press(5'h08);
    chk(33'(pump_active), 33'h0);
    load_cmd <= 1'b1;
    tick(25);
    load_cmd <= 1'b0;
    wait_rdy(60);
    chk(33'(refill_needed_out), 33'h0);
    apb(1'b1, 8'h08, 32'h2);
    steps = 0;
    trig_cmd <= 1'b1;
    tick(25);
    trig_cmd <= 1'b0;
    wait_rdy(40);
    chk(33'(steps), 33'h3);
    rd(8'h14, 33'h11);
    press(5'h10);
    rd(8'h10, 33'h0908);
    apb(1'b1, 8'h08, 32'h4);
    trig_cmd <= 1'b1;
    for (int i = 0; i < 30 && pump_active !== 1'b1; i++) tick(1);
    chk(33'(pump_active), 33'h1);
    tick(4);
    trig_cmd <= 1'b0;
    wait_rdy(25);
    apb(1'b1, 8'h00, 32'h2);
    press(5'h08);
    press(5'h04);
    tick(4);
    wait_rdy(200);
    rd(8'h14, 33'h14);
    for (int f = 1; f < 3; f++) begin
      @(posedge clk);
      fault_in <= 2'(f);
      @(posedge clk);
      fault_in <= 2'h0;
      tick(3);
      chk(33'(fault_out), 33'(f));
      chk(33'(ready_out), 33'h0);
      press(5'h01);
      chk(33'(fault_out), 33'h0);
      press(5'h08);
      chk(33'(pump_active), 33'h0);
    end
    summarize;
  end
endmodule
